// *** core/asf_pkg.sv ***
/*
  Package for the ALU status flag block: flag layout, operation codes,
  addressing modes, register offsets.
  Assumes a single core clock domain and an 8-bit data path.
*/
`default_nettype none
package asf_pkg;
  // ----------------------------------------------------------------
  // flag layout
  // ----------------------------------------------------------------
  localparam int unsigned FLAG_CARRY_BIT = 0;
  localparam int unsigned FLAG_DIGIT_BIT = 1;
  localparam int unsigned FLAG_ZERO_BIT = 2;
  localparam int unsigned FLAG_OVF_BIT = 3;
  localparam int unsigned FLAG_NEG_BIT = 4;
  localparam logic [7:0] FLAG_IMPL_MASK = 8'h1F;
  localparam logic [7:0] FLAG_RESET_VAL = 8'h00;
  localparam logic [7:0] DATA_ZERO = 8'h00;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_FLAGS = 4'h0;
  localparam logic [3:0] ADDR_CFG = 4'h1;
  localparam logic [3:0] ADDR_LAST_RES = 4'h2;
  localparam int unsigned CFG_EXT_BIT = 0;
  localparam logic [7:0] CFG_RESET_VAL = 8'h00;
  // ----------------------------------------------------------------
  // operations
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_NONE = 4'b0000,
    OP_ADD = 4'b0001,
    OP_SUB = 4'b0010,
    OP_AND = 4'b0011,
    OP_IOR = 4'b0100,
    OP_XOR = 4'b0101,
    OP_CLR = 4'b0110,
    OP_ROR = 4'b0111,
    OP_ROL = 4'b1000,
    OP_BCLR = 4'b1001,
    OP_BSET = 4'b1010,
    OP_SWAP = 4'b1011,
    OP_MOVE = 4'b1100
  } asf_op_type;
  typedef enum logic [2:0] {
    AM_INHERENT = 3'b000,
    AM_LITERAL = 3'b001,
    AM_DIRECT = 3'b010,
    AM_INDIRECT = 3'b011,
    AM_INDEXED = 3'b100
  } asf_mode_type;
  typedef struct packed {
    logic valid;
    asf_op_type op;
    asf_mode_type mode;
    logic [7:0] opa;
    logic [7:0] opb;
    logic [2:0] bit_sel;
    logic dst_is_flags;
  } asf_req_type;
  typedef struct packed {
    logic valid;
    logic [7:0] result;
    logic mode_fault;
  } asf_rsp_type;
endpackage : asf_pkg
`default_nettype wire

// *** core/asf_adder.sv ***
/*
  8-bit adder with nibble carry; subtraction adds the two's complement.
  Assumes purely combinational use by the flag block.
*/
`default_nettype none
module asf_adder (
  input wire logic [7:0] a,
  input wire logic [7:0] b,
  input wire logic sub,
  output logic [7:0] sum,
  output logic carry,
  output logic digit,
  output logic ovf
);
  logic [7:0] b_eff;
  logic [8:0] full;
  logic [4:0] low;
  assign b_eff = sub ? ~b : b;
  assign full = {1'b0, a} + {1'b0, b_eff} + {8'h00, sub};
  assign low = {1'b0, a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, sub};
  assign sum = full[7:0];
  assign carry = full[8];
  assign digit = low[4];
  assign ovf = (a[7] == b_eff[7]) && (full[7] != a[7]);
endmodule : asf_adder
`default_nettype wire

// *** core/asf_mode_check.sv ***
/*
  Addressing mode legality check.
  Assumes the extended-instruction enable is a stable level.
*/
`default_nettype none
module asf_mode_check (
  input wire asf_pkg::asf_mode_type mode,
  input wire logic extended_instr_enable,
  output logic legal
);
  assign legal = (mode != asf_pkg::AM_INDEXED) || extended_instr_enable;
endmodule : asf_mode_check
`default_nettype wire

// *** core/asf_flags.sv ***
/*
  ALU status flag generation and the flag register.
  Assumes the execution core presents one request per cycle and software
  reaches registers over a plain strobe port with read data one cycle later.
*/
// The plain strobed port and the register addresses were left to the implementer.
`default_nettype none
module asf_flags (
  input wire logic core_clk,
  input wire logic resetn,
  input wire asf_pkg::asf_req_type req,
  output asf_pkg::asf_rsp_type rsp,
  output logic [7:0] arithmetic_flags,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata
);
  // ----------------------------------------------------------------
  // datapath
  // ----------------------------------------------------------------
  logic [7:0] flags_r;
  logic [7:0] flags_nxt;
  logic [7:0] cfg_r;
  logic [7:0] last_res_r;
  logic [7:0] res;
  logic [7:0] add_sum;
  logic add_c;
  logic add_dc;
  logic add_ov;
  logic mode_ok;
  logic upd_nzov;
  logic upd_z;
  logic upd_c;
  logic do_op;
  logic [7:0] src;

  assign src = req.dst_is_flags ? flags_r : req.opa;

  asf_adder u_add (
    .a(src),
    .b(req.opb),
    .sub(req.op == asf_pkg::OP_SUB),
    .sum(add_sum),
    .carry(add_c),
    .digit(add_dc),
    .ovf(add_ov)
  );

  asf_mode_check u_mode (
    .mode(req.mode),
    .extended_instr_enable(cfg_r[asf_pkg::CFG_EXT_BIT]),
    .legal(mode_ok)
  );

  assign do_op = req.valid && mode_ok;

  always_comb begin
    res = src;
    case (req.op)
      asf_pkg::OP_ADD, asf_pkg::OP_SUB: res = add_sum;
      asf_pkg::OP_AND: res = src & req.opb;
      asf_pkg::OP_IOR: res = src | req.opb;
      asf_pkg::OP_XOR: res = src ^ req.opb;
      asf_pkg::OP_CLR: res = asf_pkg::DATA_ZERO;
      asf_pkg::OP_ROR: res = {flags_r[asf_pkg::FLAG_CARRY_BIT], src[7:1]};
      asf_pkg::OP_ROL: res = {src[6:0], flags_r[asf_pkg::FLAG_CARRY_BIT]};
      asf_pkg::OP_BCLR: res = src & ~(8'h01 << req.bit_sel);
      asf_pkg::OP_BSET: res = src | (8'h01 << req.bit_sel);
      asf_pkg::OP_SWAP: res = {src[3:0], src[7:4]};
      default: res = src;
    endcase
  end

  assign upd_nzov = (req.op == asf_pkg::OP_ADD) || (req.op == asf_pkg::OP_SUB);
  assign upd_z = upd_nzov || (req.op == asf_pkg::OP_AND) || (req.op == asf_pkg::OP_IOR)
    || (req.op == asf_pkg::OP_XOR) || (req.op == asf_pkg::OP_CLR);
  assign upd_c = upd_nzov || (req.op == asf_pkg::OP_ROR) || (req.op == asf_pkg::OP_ROL);

  // ----------------------------------------------------------------
  // flag next value
  // ----------------------------------------------------------------
  always_comb begin
    flags_nxt = flags_r;
    if (do_op && req.dst_is_flags && !upd_z && !upd_c) begin
      flags_nxt = res;
    end else if (do_op && req.dst_is_flags) begin
      // data write blocked on the five flags
      flags_nxt = flags_r;
    end else if (reg_wr && reg_addr == asf_pkg::ADDR_FLAGS) begin
      flags_nxt = reg_wdata;
    end
    if (do_op && upd_nzov) begin
      flags_nxt[asf_pkg::FLAG_NEG_BIT] = res[7];
      flags_nxt[asf_pkg::FLAG_OVF_BIT] = add_ov;
      flags_nxt[asf_pkg::FLAG_DIGIT_BIT] = add_dc;
      flags_nxt[asf_pkg::FLAG_CARRY_BIT] = add_c;
    end else if (do_op && req.op == asf_pkg::OP_ROR) begin
      flags_nxt[asf_pkg::FLAG_DIGIT_BIT] = src[4];
      flags_nxt[asf_pkg::FLAG_CARRY_BIT] = src[0];
    end else if (do_op && req.op == asf_pkg::OP_ROL) begin
      flags_nxt[asf_pkg::FLAG_DIGIT_BIT] = src[3];
      flags_nxt[asf_pkg::FLAG_CARRY_BIT] = src[7];
    end
    if (do_op && upd_z) begin
      flags_nxt[asf_pkg::FLAG_ZERO_BIT] = (res == asf_pkg::DATA_ZERO);
    end
    flags_nxt = flags_nxt & asf_pkg::FLAG_IMPL_MASK;
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // hold unless updated
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      flags_r <= asf_pkg::FLAG_RESET_VAL;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      cfg_r <= asf_pkg::CFG_RESET_VAL;
    end else if (reg_wr && reg_addr == asf_pkg::ADDR_CFG) begin
      cfg_r <= {7'h00, reg_wdata[asf_pkg::CFG_EXT_BIT]};
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rsp <= '0;
      last_res_r <= asf_pkg::DATA_ZERO;
    end else begin
      rsp.valid <= req.valid;
      rsp.result <= res;
      rsp.mode_fault <= req.valid && !mode_ok;
      if (do_op) begin
        last_res_r <= res;
      end
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      if (reg_addr == asf_pkg::ADDR_FLAGS) begin
        reg_rdata <= flags_r;
      end else if (reg_addr == asf_pkg::ADDR_CFG) begin
        reg_rdata <= cfg_r;
      end else if (reg_addr == asf_pkg::ADDR_LAST_RES) begin
        reg_rdata <= last_res_r;
      end else begin
        reg_rdata <= 8'h00;
      end
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  assign arithmetic_flags = flags_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_top_bits_zero: assert property (@(posedge core_clk) disable iff (!resetn)
    flags_r[7:5] == 3'b000) else $error("unimplemented flag bits set");
  a_neg_follows_msb: assert property (@(posedge core_clk) disable iff (!resetn)
    do_op && upd_nzov |=> flags_r[4] == $past(res[7])) else $error("negative flag wrong");
  a_zero_detect: assert property (@(posedge core_clk) disable iff (!resetn)
    do_op && upd_z |=> flags_r[2] == ($past(res) == 8'h00)) else $error("zero flag wrong");
  a_clear_sets_z: assert property (@(posedge core_clk) disable iff (!resetn)
    do_op && req.op == asf_pkg::OP_CLR && req.dst_is_flags
    |=> flags_r[2] && flags_r[1:0] == $past(flags_r[1:0])) else $error("clear of flags wrong");
  a_no_flag_ops: assert property (@(posedge core_clk) disable iff (!resetn)
    do_op && !req.dst_is_flags && !reg_wr && !upd_z && !upd_c |=> $stable(flags_r))
    else $error("flag changed by move");
  a_carry_add: assert property (@(posedge core_clk) disable iff (!resetn)
    do_op && req.op == asf_pkg::OP_ADD
    |=> flags_r[0] == ($past({1'b0, src}) + $past({1'b0, req.opb}) > 9'h0FF))
    else $error("carry wrong");
  a_rotate_carry: assert property (@(posedge core_clk) disable iff (!resetn)
    do_op && req.op == asf_pkg::OP_ROL |=> flags_r[0] == $past(src[7]))
    else $error("rotate carry wrong");
  a_mode_refused: assert property (@(posedge core_clk) disable iff (!resetn)
    req.valid && req.mode == asf_pkg::AM_INDEXED && !cfg_r[0] |=> rsp.mode_fault)
    else $error("indexed mode not refused");

  // ----------------------------------------------------------------
  // check helpers
  // ----------------------------------------------------------------
  // overflow worked out from operand and result signs
  logic chk_ovf;
  assign chk_ovf = (req.op == asf_pkg::OP_SUB)
    ? ((src[7] != req.opb[7]) && (add_sum[7] != src[7]))
    : ((src[7] == req.opb[7]) && (add_sum[7] != src[7]));

  sequence s_arith_issue;
    do_op && upd_nzov;
  endsequence

  sequence s_add_issue;
    do_op && req.op == asf_pkg::OP_ADD;
  endsequence

  sequence s_sub_issue;
    do_op && req.op == asf_pkg::OP_SUB;
  endsequence

  sequence s_ror_issue;
    do_op && req.op == asf_pkg::OP_ROR;
  endsequence

  sequence s_rol_issue;
    do_op && req.op == asf_pkg::OP_ROL;
  endsequence

  sequence s_flag_dst_data;
    do_op && req.dst_is_flags && !upd_z && !upd_c;
  endsequence

  sequence s_bus_flag_write;
    reg_wr && reg_addr == asf_pkg::ADDR_FLAGS && !do_op;
  endsequence

  sequence s_idle;
    !do_op && !reg_wr;
  endsequence

  sequence s_rd_flags;
    reg_rd && reg_addr == asf_pkg::ADDR_FLAGS;
  endsequence

  // ----------------------------------------------------------------
  // arithmetic flag checks
  // ----------------------------------------------------------------
  a_ovf_signed: assert property (@(posedge core_clk) disable iff (!resetn)
    s_arith_issue |=> flags_r[3] == $past(chk_ovf)) else $error("overflow flag wrong");

  a_digit_add: assert property (@(posedge core_clk) disable iff (!resetn)
    s_add_issue
    |=> flags_r[1] == $past(({1'b0, src[3:0]} + {1'b0, req.opb[3:0]}) > 5'h0F))
    else $error("digit carry wrong");

  a_sub_borrow: assert property (@(posedge core_clk) disable iff (!resetn)
    s_sub_issue |=> flags_r[0] == $past(src >= req.opb))
    else $error("borrow wrong");

  a_sub_digit: assert property (@(posedge core_clk) disable iff (!resetn)
    s_sub_issue |=> flags_r[1] == $past(src[3:0] >= req.opb[3:0]))
    else $error("digit borrow wrong");

  a_ror_carry: assert property (@(posedge core_clk) disable iff (!resetn)
    s_ror_issue |=> flags_r[0] == $past(src[0])) else $error("right rotate carry wrong");

  a_ror_digit: assert property (@(posedge core_clk) disable iff (!resetn)
    s_ror_issue |=> flags_r[1] == $past(src[4])) else $error("right rotate digit wrong");

  a_rol_digit: assert property (@(posedge core_clk) disable iff (!resetn)
    s_rol_issue |=> flags_r[1] == $past(src[3])) else $error("left rotate digit wrong");

  // ----------------------------------------------------------------
  // hold, destination and clear result checks
  // ----------------------------------------------------------------
  a_rotate_keeps_nzov: assert property (@(posedge core_clk) disable iff (!resetn)
    do_op && (req.op == asf_pkg::OP_ROR || req.op == asf_pkg::OP_ROL)
    && (req.dst_is_flags || !reg_wr)
    |=> flags_r[4:2] == $past(flags_r[4:2])) else $error("rotate touched other flags");

  a_logic_keeps_rest: assert property (@(posedge core_clk) disable iff (!resetn)
    do_op && upd_z && !upd_nzov && (req.dst_is_flags || !reg_wr)
    |=> flags_r[4:3] == $past(flags_r[4:3]) && flags_r[1:0] == $past(flags_r[1:0]))
    else $error("logic op touched other flags");

  a_flag_dst_data: assert property (@(posedge core_clk) disable iff (!resetn)
    s_flag_dst_data |=> flags_r == ($past(res) & 8'h1F))
    else $error("flag data write lost");

  a_bus_write_flags: assert property (@(posedge core_clk) disable iff (!resetn)
    s_bus_flag_write |=> flags_r == ($past(reg_wdata) & 8'h1F))
    else $error("bus write to flags lost");

  a_idle_hold: assert property (@(posedge core_clk) disable iff (!resetn)
    s_idle |=> $stable(flags_r)) else $error("flags changed while idle");

  a_fault_no_effect: assert property (@(posedge core_clk) disable iff (!resetn)
    req.valid && !mode_ok && !reg_wr |=> $stable(flags_r))
    else $error("refused op changed flags");

  a_clr_result: assert property (@(posedge core_clk) disable iff (!resetn)
    do_op && req.op == asf_pkg::OP_CLR |=> rsp.result == 8'h00)
    else $error("clear result not zero");

  // ----------------------------------------------------------------
  // register port and response checks
  // ----------------------------------------------------------------
  a_read_flags: assert property (@(posedge core_clk) disable iff (!resetn)
    s_rd_flags |=> reg_rdata == $past(flags_r)) else $error("flag read wrong");

  a_read_idle_zero: assert property (@(posedge core_clk) disable iff (!resetn)
    !reg_rd |=> reg_rdata == 8'h00) else $error("read data without read");

  a_rsp_follows: assert property (@(posedge core_clk) disable iff (!resetn)
    req.valid |=> rsp.valid) else $error("response missing");

  a_rsp_quiet: assert property (@(posedge core_clk) disable iff (!resetn)
    !req.valid |=> !rsp.valid) else $error("response without request");
endmodule : asf_flags
`default_nettype wire

// *** verification/asf_flags_bench.sv ***
/*
  Self-checking bench for asf_flags: corner and random ALU operations,
  flag destination cases, addressing mode refusal and register access.
  Assumes asf_pkg and the flag block are compiled before it.
*/
`default_nettype none
module asf_flags_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  asf_pkg::asf_req_type req = '0;
  asf_pkg::asf_rsp_type rsp;
  logic [7:0] arithmetic_flags;
  logic [7:0] reg_rdata;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  int mismatches = 0;
  int check_count = 0;
  logic [31:0] seed = 32'h0000_1a8e;
  logic [7:0] ef = 8'h00;
  logic [7:0] last_res = 8'h00;
  always #5 core_clk = ~core_clk;
  asf_flags i_asf_flags (.core_clk(core_clk), .resetn(resetn), .req(req), .rsp(rsp),
    .arithmetic_flags(arithmetic_flags), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check8
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : print_verdict
  // expected {result, flags}
  function automatic logic [15:0] model(input asf_pkg::asf_op_type op, input logic [7:0] a,
      input logic [7:0] b, input logic [2:0] bs, input logic [7:0] f);
    logic sb;
    logic [7:0] bb;
    logic [8:0] s;
    logic [4:0] h;
    logic [7:0] r;
    logic [7:0] nf;
    logic [8:0] sx;
    sb = (op == asf_pkg::OP_SUB);
    bb = sb ? ~b : b;
    s = {1'b0, a} + {1'b0, bb} + {8'h00, sb};
    h = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, sb};
    nf = f;
    r = a;
    case (op)
      asf_pkg::OP_ADD, asf_pkg::OP_SUB: r = s[7:0];
      asf_pkg::OP_AND: r = a & b;
      asf_pkg::OP_IOR: r = a | b;
      asf_pkg::OP_XOR: r = a ^ b;
      asf_pkg::OP_CLR: r = 8'h00;
      asf_pkg::OP_ROR: r = {f[0], a[7:1]};
      asf_pkg::OP_ROL: r = {a[6:0], f[0]};
      asf_pkg::OP_BCLR: r = a & ~(8'h01 << bs);
      asf_pkg::OP_BSET: r = a | (8'h01 << bs);
      asf_pkg::OP_SWAP: r = {a[3:0], a[7:4]};
      default: r = a;
    endcase
    sx = sb ? ({a[7], a} - {b[7], b}) : ({a[7], a} + {b[7], b});
    if (op == asf_pkg::OP_ADD || sb)
      nf[4:0] = {r[7], sx[8] ^ sx[7], r == 8'h00, sb ? (a[3:0] >= b[3:0]) : h[4],
        sb ? (a >= b) : s[8]};
    else if (op inside {asf_pkg::OP_AND, asf_pkg::OP_IOR, asf_pkg::OP_XOR, asf_pkg::OP_CLR})
      nf[2] = (r == 8'h00);
    else if (op == asf_pkg::OP_ROR) nf[1:0] = {a[4], a[0]};
    else if (op == asf_pkg::OP_ROL) nf[1:0] = {a[3], a[7]};
    return {r, nf};
  endfunction : model
  task automatic do_op(input asf_pkg::asf_op_type op, input asf_pkg::asf_mode_type md,
      input logic [7:0] a, input logic [7:0] b, input logic [2:0] bs, input logic dst,
      input logic flt);
    logic [15:0] m;
    logic upd;
    m = model(op, dst ? ef : a, b, bs, ef);
    upd = (op < asf_pkg::OP_BCLR);
    @(posedge core_clk);
    req <= '{valid: 1'b1, op: op, mode: md, opa: a, opb: b, bit_sel: bs, dst_is_flags: dst};
    @(posedge core_clk);
    req.valid <= 1'b0;
    #1;
    check8({7'h00, rsp.mode_fault}, {7'h00, flt});
    if (!flt) begin
      check8({7'h00, rsp.valid}, 8'h01);
      check8(rsp.result, m[15:8]);
      ef = (dst && !upd) ? (m[15:8] & 8'h1F) : m[7:0];
      last_res = m[15:8];
    end
    check8(arithmetic_flags, ef);
  endtask : do_op
  task automatic reg_write(input logic [3:0] ad, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= ad;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : reg_write
  task automatic reg_read(input logic [3:0] ad, input logic [7:0] exp);
    @(posedge core_clk);
    reg_addr <= ad;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    check8(reg_rdata, exp);
  endtask : reg_read
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    logic [7:0] d;
    logic [7:0] e;
    logic [7:0] ca [6] = '{8'h7F, 8'h80, 8'h0F, 8'hFF, 8'h00, 8'h55};
    logic [7:0] cb [6] = '{8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h55};
    repeat (5) @(posedge core_clk);
    resetn <= 1'b1;
    #1;
    check8(arithmetic_flags, 8'h00);
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      d = seed[7:0];
      reg_write(asf_pkg::ADDR_FLAGS, d);
      ef = d & 8'h1F;
      reg_read(asf_pkg::ADDR_FLAGS, ef);
    end
    reg_read(4'h3, 8'h00);
    reg_read(asf_pkg::ADDR_CFG, asf_pkg::CFG_RESET_VAL);
    $display("test done: register access");
    for (int i = 0; i < 6; i++) begin
      do_op(asf_pkg::OP_ADD, asf_pkg::AM_DIRECT, ca[i], cb[i], 3'd0, 1'b0, 1'b0);
      do_op(asf_pkg::OP_SUB, asf_pkg::AM_LITERAL, ca[i], cb[i], 3'd0, 1'b0, 1'b0);
    end
    reg_read(asf_pkg::ADDR_LAST_RES, last_res);
    $display("test done: corner arithmetic");
    for (int i = 0; i < 200; i++) begin
      seed = lfsr(seed);
      d = seed[7:0];
      seed = lfsr(seed);
      e = seed[7:0];
      do_op((d[3:0] == 4'h0 || d[3:0] > 4'hC) ? asf_pkg::OP_ADD : asf_pkg::asf_op_type'(d[3:0]),
        asf_pkg::asf_mode_type'({1'b0, e[1:0]}), e, d, d[7:5], d[4] & e[7], 1'b0);
    end
    $display("test done: random operations");
    reg_write(asf_pkg::ADDR_FLAGS, 8'hFB);
    ef = 8'h1B;
    do_op(asf_pkg::OP_CLR, asf_pkg::AM_DIRECT, 8'h00, 8'h00, 3'd0, 1'b1, 1'b0);
    check8(arithmetic_flags, 8'h1F);
    do_op(asf_pkg::OP_BSET, asf_pkg::AM_DIRECT, 8'h00, 8'h00, 3'd6, 1'b1, 1'b0);
    do_op(asf_pkg::OP_BCLR, asf_pkg::AM_DIRECT, 8'h00, 8'h00, 3'd2, 1'b1, 1'b0);
    $display("test done: flag destination");
    do_op(asf_pkg::OP_ADD, asf_pkg::AM_INDEXED, 8'h12, 8'h34, 3'd0, 1'b0, 1'b1);
    reg_write(asf_pkg::ADDR_CFG, 8'h01);
    reg_read(asf_pkg::ADDR_CFG, 8'h01);
    do_op(asf_pkg::OP_SUB, asf_pkg::AM_INDEXED, 8'h12, 8'h34, 3'd0, 1'b0, 1'b0);
    $display("test done: indexed mode");
    print_verdict();
  end
  initial begin
    #50000;
    mismatches++;
    print_verdict();
  end
endmodule : asf_flags_bench
`default_nettype wire
